// >>> psr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "psr_map.svh"

// Notes on behaviour
// RULE_01: Speed bit reads 1 while running 100 Mb/s twisted pair.
// RULE_02: Transmit bit reads 1 only while a packet is sent.
// RULE_03: Receive bit reads 1 only while a packet arrives.
// RULE_04: Collision bit reads 1 for as long as collision lasts.
// RULE_05: Link bit reads 1 when link is established.
// RULE_06: Duplex bit reads 1 for full duplex, 0 for half.
// RULE_07: Negotiation-mode bit reads 1 in automatic mode, 0 in manual.
// RULE_08: Negotiation-complete bit mirrors the basic status completion bit.
// RULE_09: Polarity bit reads 1 when received polarity is inverted.
// RULE_10: Pause bit reads 1 when device is pause capable.
// RULE_11: Error bit reads 1 when an error such as remote fault occurred.
// RULE_12: Negotiation-complete event interrupts only while its mask is 1.
// RULE_13: Speed-change event interrupts only while its mask is 1.
// RULE_14: Duplex-change event interrupts only while its mask is 1.
// RULE_15: Link-change event interrupts only while its mask is 1.
// RULE_16: Global enable at 0 disables all interrupt signalling; the force bit still drives the interrupt output.
// RULE_17: Force bit at 1 drives the interrupt output active.
// RULE_18: Host writes reserved mask bits as zero and ignores them.
// RULE_19: Pending bit reads 1 while an interrupt is pending.
// RULE_20: Change flags stay set until event status is read.
// RULE_21: Interrupt = enable and masked latched event, or force.
module psr_regs
	import psr_pkg::*;
(
	// Clock and reset.
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// Live line state.
	input  wire psr_line_s   line,
	// Management register port.
	input  wire psr_req_s    req,
	output logic [15:0]      rdata,
	output logic             rvalid,
	// Interrupt toward the station manager.
	output logic             mgmt_irq_out
);

	logic [15:0] phy_live_status;
	logic [15:0] next_phy_live_status;
	logic [15:0] event_interrupt_mask;
	logic [15:0] next_event_interrupt_mask;
	logic [7:4]  evt_flag;
	logic [7:4]  next_evt_flag;
	logic [7:4]  evt_pulse;
	logic [2:0]  prev_line;
	logic [2:0]  next_prev_line;
	logic        prev_done;
	logic        next_prev_done;
	logic        pending;
	logic [15:0] next_rdata;
	logic        next_rvalid;
	logic        next_irq;
	logic        evt_read;

	always_comb
	begin
		next_phy_live_status = `PSR_STATUS_RESET;
		next_phy_live_status[`PSR_ST_SPEED]    = line.speed_100;    // [RULE_01]
		next_phy_live_status[`PSR_ST_TX]       = line.tx_active;    // [RULE_02]
		next_phy_live_status[`PSR_ST_RX]       = line.rx_active;    // [RULE_03]
		next_phy_live_status[`PSR_ST_COL]      = line.collision;    // [RULE_04]
		next_phy_live_status[`PSR_ST_LINK]     = line.link_up;      // [RULE_05]
		next_phy_live_status[`PSR_ST_DUPLEX]   = line.full_duplex;  // [RULE_06]
		next_phy_live_status[`PSR_ST_AN_MODE]  = line.an_enabled;   // [RULE_07]
		next_phy_live_status[`PSR_ST_AN_DONE]  = line.an_complete;  // [RULE_08]
		next_phy_live_status[`PSR_ST_POLARITY] = line.polarity_inv; // [RULE_09]
		next_phy_live_status[`PSR_ST_PAUSE]    = line.pause_cap;    // [RULE_10]
		next_phy_live_status[`PSR_ST_ERROR]    = line.error_seen;   // [RULE_11]
	end

	// Changes are judged against the sampled status so a glitch on the inputs
	// between samples cannot raise an event without a visible status change.
	always_comb
	begin
		next_prev_line = {next_phy_live_status[`PSR_ST_SPEED],
			next_phy_live_status[`PSR_ST_DUPLEX],
			next_phy_live_status[`PSR_ST_LINK]};
		next_prev_done = next_phy_live_status[`PSR_ST_AN_DONE];
		evt_pulse[`PSR_EV_SPEED]   = prev_line[2] ^ next_prev_line[2];
		evt_pulse[`PSR_EV_DUPLEX]  = prev_line[1] ^ next_prev_line[1];
		evt_pulse[`PSR_EV_LINK]    = prev_line[0] ^ next_prev_line[0];
		evt_pulse[`PSR_EV_AN_DONE] = next_prev_done & ~prev_done;
		evt_read = req.rd && (req.addr == `PSR_ADDR_EVT_STATUS);
		// A new event in the reading cycle survives the clear.
		next_evt_flag = (evt_read ? 4'h0 : evt_flag) | evt_pulse; // [RULE_20]
		next_event_interrupt_mask = event_interrupt_mask;
		if (req.wr && (req.addr == `PSR_ADDR_IRQ_MASK))
		begin
			// Reserved bits are dropped; they always read as zero.
			next_event_interrupt_mask = req.wdata & `PSR_MASK_WMASK; // [RULE_18]
		end
	end

	// The mask gates each latched event; the global enable gates them all.
	always_comb
	begin
		pending = |(evt_flag & event_interrupt_mask[7:4]); // [RULE_12] [RULE_13] [RULE_14] [RULE_15]
		next_irq = (event_interrupt_mask[`PSR_MK_GLOBAL] & pending) // [RULE_16] [RULE_21]
			| event_interrupt_mask[`PSR_MK_FORCE]; // [RULE_17]
	end

	always_comb
	begin
		next_rdata  = 16'h0000;
		next_rvalid = req.rd;
		case (req.addr)
			`PSR_ADDR_LIVE_STATUS: next_rdata = phy_live_status;
			`PSR_ADDR_IRQ_MASK:    next_rdata = event_interrupt_mask;
			`PSR_ADDR_EVT_STATUS:
			begin
				next_rdata[7:4] = evt_flag;
				next_rdata[`PSR_EV_PENDING] = mgmt_irq_out; // [RULE_19]
			end
			default:               next_rdata = 16'h0000;
		endcase
		if (!req.rd)
		begin
			next_rdata = rdata;
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			phy_live_status      <= `PSR_STATUS_RESET;
			event_interrupt_mask <= `PSR_MASK_RESET;
			evt_flag             <= 4'h0;
			prev_line            <= 3'h0;
			prev_done            <= 1'b0;
			rdata                <= 16'h0000;
			rvalid               <= 1'b0;
			mgmt_irq_out         <= 1'b0;
		end
		else
		begin
			phy_live_status      <= next_phy_live_status;
			event_interrupt_mask <= next_event_interrupt_mask;
			evt_flag             <= next_evt_flag;
			prev_line            <= next_prev_line;
			prev_done            <= next_prev_done;
			rdata                <= next_rdata;
			rvalid               <= next_rvalid;
			mgmt_irq_out         <= next_irq;
		end
	end

	a_live_speed: assert property ( // [RULE_01]
		@(posedge core_clk) disable iff (!resetn)
		1'b1 |=> phy_live_status[`PSR_ST_SPEED] == $past(line.speed_100))
		else $error("speed bit does not follow line");

	a_live_tx: assert property ( // [RULE_02]
		@(posedge core_clk) disable iff (!resetn)
		line.tx_active |=> phy_live_status[`PSR_ST_TX])
		else $error("transmit bit not set");

	a_tx_idle: assert property ( // [RULE_02]
		@(posedge core_clk) disable iff (!resetn)
		!line.tx_active |=> !phy_live_status[`PSR_ST_TX])
		else $error("transmit bit set while idle");

	a_live_rx: assert property ( // [RULE_03]
		@(posedge core_clk) disable iff (!resetn)
		!line.rx_active |=> !phy_live_status[`PSR_ST_RX])
		else $error("receive bit set while idle");

	a_rx_busy: assert property ( // [RULE_03]
		@(posedge core_clk) disable iff (!resetn)
		line.rx_active |=> phy_live_status[`PSR_ST_RX])
		else $error("receive bit not set");

	a_live_col: assert property ( // [RULE_04]
		@(posedge core_clk) disable iff (!resetn)
		line.collision [*2] |=> phy_live_status[`PSR_ST_COL])
		else $error("collision bit dropped");

	a_col_clear: assert property ( // [RULE_04]
		@(posedge core_clk) disable iff (!resetn)
		!line.collision |=> !phy_live_status[`PSR_ST_COL])
		else $error("collision bit set without collision");

	a_live_link: assert property ( // [RULE_05]
		@(posedge core_clk) disable iff (!resetn)
		$rose(line.link_up) |=> phy_live_status[`PSR_ST_LINK])
		else $error("link bit not set");

	a_link_down: assert property ( // [RULE_05]
		@(posedge core_clk) disable iff (!resetn)
		!line.link_up |=> !phy_live_status[`PSR_ST_LINK])
		else $error("link bit set while link is down");

	a_live_duplex: assert property ( // [RULE_06]
		@(posedge core_clk) disable iff (!resetn)
		1'b1 |=> phy_live_status[`PSR_ST_DUPLEX] == $past(line.full_duplex))
		else $error("duplex bit wrong");

	a_live_anmode: assert property ( // [RULE_07]
		@(posedge core_clk) disable iff (!resetn)
		1'b1 |=> phy_live_status[`PSR_ST_AN_MODE] == $past(line.an_enabled))
		else $error("negotiation mode bit wrong");

	a_live_andone: assert property ( // [RULE_08]
		@(posedge core_clk) disable iff (!resetn)
		1'b1 |=> phy_live_status[`PSR_ST_AN_DONE] == $past(line.an_complete))
		else $error("negotiation done bit wrong");

	a_live_polarity: assert property ( // [RULE_09]
		@(posedge core_clk) disable iff (!resetn)
		1'b1 |=> phy_live_status[`PSR_ST_POLARITY] == $past(line.polarity_inv))
		else $error("polarity bit wrong");

	a_live_pause: assert property ( // [RULE_10]
		@(posedge core_clk) disable iff (!resetn)
		1'b1 |=> phy_live_status[`PSR_ST_PAUSE] == $past(line.pause_cap))
		else $error("pause bit wrong");

	a_live_error: assert property ( // [RULE_11]
		@(posedge core_clk) disable iff (!resetn)
		1'b1 |=> phy_live_status[`PSR_ST_ERROR] == $past(line.error_seen))
		else $error("error bit wrong");

	// The flag is set on the same edge that the status bit moves.
	a_andone_evt: assert property ( // [RULE_12]
		@(posedge core_clk) disable iff (!resetn)
		$rose(phy_live_status[`PSR_ST_AN_DONE]) |-> evt_flag[`PSR_EV_AN_DONE])
		else $error("negotiation done event not latched");

	a_speed_evt: assert property ( // [RULE_20]
		@(posedge core_clk) disable iff (!resetn)
		$changed(phy_live_status[`PSR_ST_SPEED]) |-> evt_flag[`PSR_EV_SPEED])
		else $error("speed change not latched");

	a_duplex_evt: assert property ( // [RULE_20]
		@(posedge core_clk) disable iff (!resetn)
		$changed(phy_live_status[`PSR_ST_DUPLEX]) |-> evt_flag[`PSR_EV_DUPLEX])
		else $error("duplex change not latched");

	a_link_evt: assert property ( // [RULE_20]
		@(posedge core_clk) disable iff (!resetn)
		$changed(phy_live_status[`PSR_ST_LINK]) |-> evt_flag[`PSR_EV_LINK])
		else $error("link change not latched");

	a_flag_hold: assert property ( // [RULE_20]
		@(posedge core_clk) disable iff (!resetn)
		evt_flag[`PSR_EV_LINK] && !evt_read |=> evt_flag[`PSR_EV_LINK])
		else $error("link change flag lost before read");

	a_flag_clear: assert property ( // [RULE_20]
		@(posedge core_clk) disable iff (!resetn)
		evt_read && prev_line[0] == line.link_up |=> !evt_flag[`PSR_EV_LINK])
		else $error("link change flag not cleared by read");

	a_irq_andone: assert property ( // [RULE_12]
		@(posedge core_clk) disable iff (!resetn)
		evt_flag[`PSR_EV_AN_DONE] && event_interrupt_mask[`PSR_MK_AN_DONE]
		&& event_interrupt_mask[`PSR_MK_GLOBAL] |=> mgmt_irq_out)
		else $error("negotiation done event did not interrupt");

	a_irq_speed: assert property ( // [RULE_13]
		@(posedge core_clk) disable iff (!resetn)
		evt_flag[`PSR_EV_SPEED] && event_interrupt_mask[`PSR_MK_SPEED]
		&& event_interrupt_mask[`PSR_MK_GLOBAL] |=> mgmt_irq_out)
		else $error("speed event did not interrupt");

	a_irq_duplex: assert property ( // [RULE_14]
		@(posedge core_clk) disable iff (!resetn)
		evt_flag[`PSR_EV_DUPLEX] && event_interrupt_mask[`PSR_MK_DUPLEX]
		&& event_interrupt_mask[`PSR_MK_GLOBAL] |=> mgmt_irq_out)
		else $error("duplex event did not interrupt");

	a_irq_link: assert property ( // [RULE_15]
		@(posedge core_clk) disable iff (!resetn)
		evt_flag[`PSR_EV_LINK] && event_interrupt_mask[`PSR_MK_LINK]
		&& event_interrupt_mask[`PSR_MK_GLOBAL] |=> mgmt_irq_out)
		else $error("link event did not interrupt");

	a_irq_masked: assert property ( // [RULE_13]
		@(posedge core_clk) disable iff (!resetn)
		(evt_flag & event_interrupt_mask[7:4]) == 4'h0
		&& !event_interrupt_mask[`PSR_MK_FORCE] |=> !mgmt_irq_out)
		else $error("interrupt raised by masked event");

	a_irq_global: assert property ( // [RULE_16]
		@(posedge core_clk) disable iff (!resetn)
		!event_interrupt_mask[`PSR_MK_GLOBAL]
		&& !event_interrupt_mask[`PSR_MK_FORCE] |=> !mgmt_irq_out)
		else $error("interrupt while globally disabled");

	a_irq_force: assert property ( // [RULE_17]
		@(posedge core_clk) disable iff (!resetn)
		event_interrupt_mask[`PSR_MK_FORCE] |=> mgmt_irq_out)
		else $error("force bit did not drive interrupt");

	a_mask_resv: assert property ( // [RULE_18]
		@(posedge core_clk) disable iff (!resetn)
		(event_interrupt_mask & ~`PSR_MASK_WMASK) == 16'h0000)
		else $error("reserved mask bits stored");

	a_mask_write: assert property ( // [RULE_16]
		@(posedge core_clk) disable iff (!resetn)
		req.wr && req.addr == `PSR_ADDR_IRQ_MASK |=> event_interrupt_mask
		== ($past(req.wdata) & `PSR_MASK_WMASK))
		else $error("mask write not stored");

	a_read_mask: assert property ( // [RULE_18]
		@(posedge core_clk) disable iff (!resetn)
		req.rd && req.addr == `PSR_ADDR_IRQ_MASK
		|=> rdata == $past(event_interrupt_mask))
		else $error("mask read returned wrong value");

	a_read_status: assert property ( // [RULE_05]
		@(posedge core_clk) disable iff (!resetn)
		req.rd && req.addr == `PSR_ADDR_LIVE_STATUS
		|=> rdata == $past(phy_live_status))
		else $error("status read returned wrong value");

	a_read_unmapped: assert property ( // [RULE_18]
		@(posedge core_clk) disable iff (!resetn)
		req.rd && req.addr > `PSR_ADDR_EVT_STATUS |=> rdata == 16'h0000)
		else $error("unmapped read not zero");

	a_pending_bit: assert property ( // [RULE_19]
		@(posedge core_clk) disable iff (!resetn)
		req.rd && req.addr == `PSR_ADDR_EVT_STATUS
		|=> rdata[`PSR_EV_PENDING] == $past(mgmt_irq_out))
		else $error("pending bit does not show the interrupt");

	a_rvalid_pulse: assert property ( // [RULE_19]
		@(posedge core_clk) disable iff (!resetn)
		1'b1 |=> rvalid == $past(req.rd))
		else $error("read answer not one cycle after request");

	// Read data must stand between reads; the host may sample it late.
	a_rdata_hold: assert property ( // [RULE_19]
		@(posedge core_clk) disable iff (!resetn)
		!req.rd |=> $stable(rdata))
		else $error("read data changed without a read");

endmodule // psr_regs
`default_nettype wire

// >>> psr_map.svh
`ifndef PSR_MAP_SVH
`define PSR_MAP_SVH

// Register addresses on the management port.
`define PSR_ADDR_LIVE_STATUS 5'h11
`define PSR_ADDR_IRQ_MASK    5'h12
`define PSR_ADDR_EVT_STATUS  5'h13

// Live status bit positions.
`define PSR_ST_SPEED     14
`define PSR_ST_TX        13
`define PSR_ST_RX        12
`define PSR_ST_COL       11
`define PSR_ST_LINK      10
`define PSR_ST_DUPLEX    9
`define PSR_ST_AN_MODE   8
`define PSR_ST_AN_DONE   7
`define PSR_ST_POLARITY  5
`define PSR_ST_PAUSE     4
`define PSR_ST_ERROR     3

// Mask register bit positions.
`define PSR_MK_AN_DONE   7
`define PSR_MK_SPEED     6
`define PSR_MK_DUPLEX    5
`define PSR_MK_LINK      4
`define PSR_MK_GLOBAL    1
`define PSR_MK_FORCE     0

// Event status bit positions.
`define PSR_EV_AN_DONE   7
`define PSR_EV_SPEED     6
`define PSR_EV_DUPLEX    5
`define PSR_EV_LINK      4
`define PSR_EV_PENDING   2

// Writable bits of the mask register, and reset values.
`define PSR_MASK_WMASK   16'h00F3
`define PSR_MASK_RESET   16'h0000
`define PSR_STATUS_RESET 16'h0000

`endif

// >>> psr_pkg.sv
package psr_pkg;

	// Live line state presented by the physical layer.
	typedef struct packed {
		logic speed_100;
		logic tx_active;
		logic rx_active;
		logic collision;
		logic link_up;
		logic full_duplex;
		logic an_enabled;
		logic an_complete;
		logic polarity_inv;
		logic pause_cap;
		logic error_seen;
	} psr_line_s;

	// Management register access request.
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [4:0] addr;
		logic [15:0] wdata;
	} psr_req_s;

endpackage

// >>> psr_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "psr_map.svh"
module psr_host
	import psr_pkg::*;
(
	// Clock.
	input  wire logic        core_clk,
	// Management port.
	output var  psr_req_s    req,
	input  wire logic [15:0] rdata,
	input  wire logic        rvalid
);
	initial req = '0;

	task automatic wr_reg(input logic [4:0] a, input logic [15:0] v);
		@(posedge core_clk);
		req.addr  <= a;
		req.wdata <= v & `PSR_MASK_WMASK;
		req.wr    <= 1'b1;
		@(posedge core_clk);
		req.wr <= 1'b0;
	endtask

	// The answer stands exactly one cycle after the request; a late one fails.
	task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
		@(posedge core_clk);
		req.addr <= a;
		req.rd   <= 1'b1;
		@(posedge core_clk);
		req.rd <= 1'b0;
		#1;
		v = (rvalid === 1'b1) ? rdata : 'x;
	endtask
endmodule // psr_host
`default_nettype wire

// >>> phy_status_and_irq_enable_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "psr_map.svh"
`define CHK(nm, x, y) \
	begin \
		n_compared++; \
		if ((y) !== (x)) \
		begin \
			fail_count++; \
			$display("BAD %s exp %h got %h", nm, x, y); \
		end \
	end
module phy_status_and_irq_enable_regs_tb
	import psr_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        resetn   = 1'b0;
	psr_line_s   line     = '0;
	psr_req_s    req;
	logic [15:0] rdata;
	logic        rvalid;
	logic        mgmt_irq_out;
	logic [31:0] seed     = 32'hE4516443;
	logic [10:0] cur      = '0;
	logic [7:0]  flags    = '0;
	logic [15:0] mask     = '0;
	logic [15:0] d;
	int          fail_count = 0;
	int          n_compared = 0;
	int          cycles     = 0;
	int          lb[4]      = '{3, 10, 5, 6};

	always #50 core_clk = ~core_clk;

	psr_regs DUT (.core_clk(core_clk), .resetn(resetn), .line(line),
		.req(req), .rdata(rdata), .rvalid(rvalid),
		.mgmt_irq_out(mgmt_irq_out));
	psr_host HOST (.core_clk(core_clk), .req(req), .rdata(rdata),
		.rvalid(rvalid));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic exp_irq();
		return (mask[1] & |(flags[7:4] & mask[7:4])) | mask[0];
	endfunction

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			final_report();
		end
	end

	// Model flags each speed, duplex and link change and each negotiation-complete rise here, so no line edge is missed.
	task automatic set_line(input logic [10:0] v);
		@(posedge core_clk);
		line <= psr_line_s'(v);
		flags[6] |= v[10] ^ cur[10];
		flags[5] |= v[5] ^ cur[5];
		flags[4] |= v[6] ^ cur[6];
		flags[7] |= v[3] & ~cur[3];
		cur = v;
		repeat (4) @(posedge core_clk);
	endtask

	task automatic set_mask(input logic [15:0] v);
		HOST.wr_reg(`PSR_ADDR_IRQ_MASK, v);
		mask = v & `PSR_MASK_WMASK;
		repeat (2) @(posedge core_clk);
	endtask

	task automatic chk_evt();
		HOST.rd_reg(`PSR_ADDR_EVT_STATUS, d);
		`CHK("evt", {8'h00, flags[7:4], 1'b0, exp_irq(), 2'h0}, d)
		flags = '0;
		repeat (3) @(posedge core_clk);
		`CHK("irq_clr", exp_irq(), mgmt_irq_out)
	endtask

	task automatic chk_status();
		logic [15:0] e;
		e = {1'b0, cur[10:3], 1'b0, cur[2:0], 3'h0};
		HOST.rd_reg(`PSR_ADDR_LIVE_STATUS, d);
		`CHK("st_a", e[15:11], d[15:11])
		`CHK("st_b", e[10:7], d[10:7])
		`CHK("st_c", e[6:0], d[6:0])
	endtask

	initial
	begin
		repeat (20) @(posedge core_clk);
		`CHK("rst", 18'h00000, {rdata, rvalid, mgmt_irq_out})
		resetn <= 1'b1;
		for (int i = 0; i < 12; i++)
		begin
			seed = lfsr(seed);
			set_line(seed[10:0]);
			chk_status();
			chk_evt();
		end
		$display("test status done");
		seed = lfsr(seed);
		set_mask(seed[15:0]);
		HOST.wr_reg(`PSR_ADDR_LIVE_STATUS, 16'hFFFF);
		chk_status();
		HOST.rd_reg(`PSR_ADDR_IRQ_MASK, d);
		`CHK("mask", mask, d)
		HOST.rd_reg(5'h1F, d);
		`CHK("unmapped", 16'h0000, d)
		$display("test registers done");
		for (int i = 0; i < 16; i++)
		begin
			set_line(cur & ~(11'h001 << lb[i[1:0]]));
			chk_evt();
			set_mask(16'(i[2]) << (7 - i[1:0]) | 16'(i[3]) << 1);
			set_line(cur | (11'h001 << lb[i[1:0]]));
			`CHK("irq", exp_irq(), mgmt_irq_out)
			chk_evt();
		end
		set_mask(16'h0001);
		`CHK("force", 1'b1, mgmt_irq_out)
		chk_evt();
		$display("test interrupts done");
		final_report();
	end
endmodule // phy_status_and_irq_enable_regs_tb
`default_nettype wire
